// [pols_dev_model.sv]
// Behavioural model of the attached device and the port state
`timescale 1ns/1ns
module pols_dev_model
   import pols_pkg::*;
(
   // Clock and bench commands
   input wire logic aclk,
   input wire logic [1:0] ls_cmd,
   input wire logic oc_cmd,
   input wire logic conn_cmd,
   // Pins toward the block
   output pols_pkg::pols_line_t line_in = 2'h0,
   output logic overcurrent_in = 1'b0,
   output logic port_enabled = 1'b0,
   output logic dev_connected = 1'b0
);
   // Host pull-downs leave SE0 when nothing is attached
   always @(posedge aclk) begin
      line_in <= conn_cmd ? ls_cmd : 2'h0;
      overcurrent_in <= oc_cmd;
      dev_connected <= conn_cmd;
      // Port stays disabled while speed is being detected
      port_enabled <= 1'b0;
   end
endmodule : pols_dev_model

// [pols_pkg.sv]
// Package for the port owner, power and line-state block
package pols_pkg;
   // Register byte offsets
   localparam logic [7:0] POLS_PORT_OFS = 8'h00;
   localparam logic [7:0] POLS_CFG_OFS = 8'h04;
   localparam logic [7:0] POLS_STAT_OFS = 8'h08;
   localparam logic [7:0] POLS_MASK_OFS = 8'h0C;
   // Port register field positions
   localparam int POLS_PTC_LSB = 16;
   localparam int POLS_PO_BIT = 13;
   localparam int POLS_PP_BIT = 12;
   localparam int POLS_LS_LSB = 10;
   localparam int POLS_PE_BIT = 2;
   localparam int POLS_CCS_BIT = 0;
   // Config register fields
   localparam int POLS_CF_BIT = 0;
   localparam int POLS_PPC_BIT = 4;
   // Event bits
   localparam int POLS_EV_OC = 0;
   localparam int POLS_EV_PO = 1;
   localparam int POLS_EV_LS = 2;
   localparam int POLS_EV_W = 3;
   // Reset values
   localparam logic POLS_PO_RST = 1'b1;
   localparam logic POLS_PP_RST = 1'b0;
   localparam logic [3:0] POLS_PTC_RST = 4'h0;
   // Test selector encodings
   typedef enum logic [3:0] {
      POLS_TM_OFF = 4'h0,
      POLS_TM_J = 4'h1,
      POLS_TM_K = 4'h2,
      POLS_TM_SE0_NAK = 4'h3,
      POLS_TM_PACKET = 4'h4,
      POLS_TM_FORCE_EN = 4'h5
   } pols_test_t;
   // Line states
   localparam logic [1:0] POLS_LS_K = 2'b01;
   // Bus write state
   typedef enum logic [1:0] {
      POLS_WS_IDLE = 2'b00,
      POLS_WS_RESP = 2'b01
   } pols_wst_t;
   // USB line pins as a group
   typedef struct packed {
      logic dp;
      logic dm;
   } pols_line_t;
   // Controls to the port logic
   typedef struct packed {
      logic owner_companion;
      logic power_on;
      logic drive_j;
      logic drive_k;
      logic test_se0_nak;
      logic test_packet;
      logic test_force_en;
   } pols_ctl_t;
endpackage : pols_pkg

// [pols_port.sv]
// Port owner, power switch and line-state logic with AXI4-Lite registers
//
// Function
// - Selector zero is normal; 0001b drives J, 0010b drives K.
// - 0011b SE0_NAK, 0100b test packet, 0101b force enable, rest reserved.
// - Owner flag resets to 1, cleared when configured flag rises.
// - Owner flag held at 1 while configured flag is 0.
// - Owner flag 1 hands port control to the companion controller.
// - Without switch capability, power flag reads 1, port always powered.
// - With switch capability, power flag is the switch state.
// - Power flag 0 makes port nonfunctional with no status.
// - Overcurrent with switch capability clears the power flag.
// - Line-state bit 11 is DP, bit 10 is DM.
// - Line state valid when port disabled and connected; undefined unpowered.
`timescale 1ns/1ns
module pols_port
   import pols_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Port pins and port state
   input wire pols_pkg::pols_line_t line_in,
   input wire logic overcurrent_in,
   input wire logic port_enabled,
   input wire logic dev_connected,
   // Port controls and interrupt
   output pols_pkg::pols_ctl_t port_ctl,
   output logic irq
);
   import pols_pkg::*;

   typedef struct packed {
      logic [1:0] line_s1;
      logic [1:0] line_s2;
      logic oc_s1;
      logic oc_s2;
      logic cf;
      logic cf_prev;
      logic power_switch_capability;
      logic po;
      logic pp;
      logic [3:0] port_test_selector;
      logic [3:0] stat;
      logic [3:0] mask;
      logic [1:0] ls_prev;
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      pols_wst_t wst;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      pols_ctl_t ctl;
      logic irq;
   } pols_state_t;

   pols_state_t s_q;
   pols_state_t s_d;
   logic [31:0] port_word;
   logic do_wr;
   logic pp_eff;
   logic oc_hit;

   always_comb begin
      // Port register image
      port_word = 32'h0000_0000;
      pp_eff = s_q.power_switch_capability ? s_q.pp : 1'b1;
      port_word[POLS_PTC_LSB +: 4] = s_q.port_test_selector;
      port_word[POLS_PO_BIT] = s_q.po;
      port_word[POLS_PP_BIT] = pp_eff;
      // Unpowered port shows zero line state; bits 15:14 stay zero
      if (pp_eff) begin
         port_word[POLS_LS_LSB +: 2] = s_q.line_s2;
      end
      port_word[POLS_PE_BIT] = port_enabled & pp_eff;
      port_word[POLS_CCS_BIT] = dev_connected & pp_eff;
      oc_hit = s_q.oc_s2 & s_q.power_switch_capability & s_q.pp;
      do_wr = s_q.aw_got & s_q.w_got & (s_q.wst == POLS_WS_IDLE);

      s_d = s_q;
      s_d.line_s1 = {line_in.dp, line_in.dm};
      s_d.line_s2 = s_q.line_s1;
      s_d.oc_s1 = overcurrent_in;
      s_d.oc_s2 = s_q.oc_s1;
      s_d.cf_prev = s_q.cf;
      s_d.ls_prev = s_q.line_s2;

      // Address and data taken in either order
      if (s_axi_awvalid && s_axi_awready) begin
         s_d.aw_got = 1'b1;
         s_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_d.w_got = 1'b1;
         s_d.w_data = s_axi_wdata;
         s_d.w_strb = s_axi_wstrb;
      end
      if (do_wr) begin
         s_d.aw_got = 1'b0;
         s_d.w_got = 1'b0;
         s_d.wst = POLS_WS_RESP;
         s_d.bvalid = 1'b1;
         s_d.bresp = 2'b00;
         unique case (s_q.aw_addr)
            POLS_PORT_OFS: begin
               if (s_q.w_strb[2]) begin
                  s_d.port_test_selector = s_q.w_data[POLS_PTC_LSB +: 4];
               end
               if (s_q.w_strb[1]) begin
                  s_d.po = s_q.w_data[POLS_PO_BIT];
                  if (s_q.power_switch_capability) begin
                     s_d.pp = s_q.w_data[POLS_PP_BIT];
                  end
               end
            end
            POLS_CFG_OFS: begin
               if (s_q.w_strb[0]) begin
                  s_d.cf = s_q.w_data[POLS_CF_BIT];
                  s_d.power_switch_capability = s_q.w_data[POLS_PPC_BIT];
               end
            end
            POLS_STAT_OFS: begin
               if (s_q.w_strb[0]) begin
                  s_d.stat = s_q.stat & ~s_q.w_data[3:0];
               end
            end
            POLS_MASK_OFS: begin
               if (s_q.w_strb[0]) begin
                  s_d.mask = s_q.w_data[3:0];
               end
            end
            default: s_d.bresp = 2'b10;
         endcase
      end
      if (s_q.wst == POLS_WS_RESP && s_axi_bready) begin
         s_d.bvalid = 1'b0;
         s_d.wst = POLS_WS_IDLE;
      end

      // Read channel
      if (s_axi_arvalid && s_axi_arready) begin
         s_d.rvalid = 1'b1;
         s_d.rresp = 2'b00;
         unique case (s_axi_araddr)
            POLS_PORT_OFS: s_d.rdata = port_word;
            POLS_CFG_OFS: s_d.rdata = {27'h000_0000, s_q.power_switch_capability, 3'h0, s_q.cf};
            POLS_STAT_OFS: s_d.rdata = {28'h000_0000, s_q.stat};
            POLS_MASK_OFS: s_d.rdata = {28'h000_0000, s_q.mask};
            default: begin
               s_d.rdata = 32'h0000_0000;
               s_d.rresp = 2'b10;
            end
         endcase
      end else if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end

      // Power switch and overcurrent
      if (!s_q.power_switch_capability) begin
         s_d.pp = 1'b1;
      end else if (oc_hit) begin
         s_d.pp = 1'b0;
      end

      // Owner: rising configured flag clears, low configured flag forces one
      if (!s_q.cf) begin
         s_d.po = 1'b1;
      end else if (!s_q.cf_prev) begin
         s_d.po = 1'b0;
      end

      // Sticky events; set wins over the clear above
      if (oc_hit) begin
         s_d.stat[POLS_EV_OC] = 1'b1;
      end
      if (s_d.po != s_q.po) begin
         s_d.stat[POLS_EV_PO] = 1'b1;
      end
      if (s_q.line_s2 != s_q.ls_prev && !port_enabled && dev_connected) begin
         s_d.stat[POLS_EV_LS] = 1'b1;
      end
      s_d.stat[POLS_EV_W] = 1'b0;
      s_d.irq = |(s_d.stat & s_d.mask);

      // Port controls; unpowered or companion-owned port stays idle
      s_d.ctl.owner_companion = s_d.po;
      s_d.ctl.power_on = s_d.power_switch_capability ? s_d.pp : 1'b1;
      s_d.ctl.drive_j = 1'b0;
      s_d.ctl.drive_k = 1'b0;
      s_d.ctl.test_se0_nak = 1'b0;
      s_d.ctl.test_packet = 1'b0;
      s_d.ctl.test_force_en = 1'b0;
      if (!s_d.po && s_d.ctl.power_on) begin
         case (pols_test_t'(s_d.port_test_selector))
            POLS_TM_J: s_d.ctl.drive_j = 1'b1;
            POLS_TM_K: s_d.ctl.drive_k = 1'b1;
            POLS_TM_SE0_NAK: s_d.ctl.test_se0_nak = 1'b1;
            POLS_TM_PACKET: s_d.ctl.test_packet = 1'b1;
            POLS_TM_FORCE_EN: s_d.ctl.test_force_en = 1'b1;
            default: ; // Zero is normal use; reserved codes do nothing
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
         s_q.po <= POLS_PO_RST;
         s_q.pp <= POLS_PP_RST;
         s_q.port_test_selector <= POLS_PTC_RST;
         s_q.wst <= POLS_WS_IDLE;
         s_q.ctl.owner_companion <= POLS_PO_RST;
         s_q.ctl.power_on <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // Ready only while a slot is free; one write in flight
   always_comb begin
      s_axi_awready = !s_q.aw_got && s_q.wst == POLS_WS_IDLE;
      s_axi_wready = !s_q.w_got && s_q.wst == POLS_WS_IDLE;
      s_axi_arready = !s_q.rvalid;
   end
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_rvalid = s_q.rvalid;
   assign s_axi_rdata = s_q.rdata;
   assign s_axi_rresp = s_q.rresp;
   assign port_ctl = s_q.ctl;
   assign irq = s_q.irq;

   // Assertions
   sequence cf_rise_s;
      !s_q.cf ##1 s_q.cf;
   endsequence

   a_owner_cf_low: assert property (@(posedge aclk) disable iff (!aresetn)
      !s_q.cf |=> s_q.po) else $error("owner not held while cf low");
   a_owner_cf_rise: assert property (@(posedge aclk) disable iff (!aresetn)
      cf_rise_s |=> !s_q.po) else $error("owner not cleared on cf rise");
   a_power_fixed: assert property (@(posedge aclk) disable iff (!aresetn)
      !s_q.power_switch_capability |-> port_word[POLS_PP_BIT]) else $error("power flag not one");
   a_oc_removes: assert property (@(posedge aclk) disable iff (!aresetn)
      oc_hit |=> !s_q.pp) else $error("overcurrent left power on");
   a_line_map: assert property (@(posedge aclk) disable iff (!aresetn)
      pp_eff |-> port_word[11:10] == s_q.line_s2) else $error("line state mapping");
   a_unpowered_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
      !pp_eff |-> port_word[POLS_LS_LSB +: 2] == 2'b00 && !port_word[POLS_CCS_BIT])
      else $error("unpowered port reports status");
   a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      port_word[15:14] == 2'b00) else $error("reserved bits not zero");
   a_owner_idle: assert property (@(posedge aclk) disable iff (!aresetn)
      port_ctl.owner_companion |-> !port_ctl.drive_j && !port_ctl.drive_k
      && !port_ctl.test_packet) else $error("companion port driven");
   // Controls register from the same next state, so they track s_q in the same cycle
   a_test_j: assert property (@(posedge aclk) disable iff (!aresetn)
      s_q.port_test_selector == 4'h1 && !s_q.po && pp_eff |-> port_ctl.drive_j)
      else $error("J test not driven");
   a_test_packet: assert property (@(posedge aclk) disable iff (!aresetn)
      s_q.port_test_selector == 4'h4 && !s_q.po && pp_eff |-> port_ctl.test_packet)
      else $error("test packet not selected");
endmodule : pols_port

// [tb_pols_port.sv]
// Testbench for the port owner, power and line-state block
`timescale 1ns/1ns
module tb_pols_port;
   import pols_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, irq, oc_in, pen, dcon;
   logic [1:0] bresp, rresp, rsp;
   logic [31:0] rdata, rd;
   logic [1:0] ls_cmd = 2'h0;
   logic oc_cmd = 1'b0, conn_cmd = 1'b1;
   pols_line_t line_in;
   pols_ctl_t ctl;
   int n_errors = 0, n_checks = 0, cyc = 0;
   always #4 aclk = ~aclk;
   pols_port DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .line_in(line_in), .overcurrent_in(oc_in),
      .port_enabled(pen), .dev_connected(dcon), .port_ctl(ctl), .irq(irq));
   pols_dev_model model (.aclk(aclk), .ls_cmd(ls_cmd), .oc_cmd(oc_cmd),
      .conn_cmd(conn_cmd), .line_in(line_in), .overcurrent_in(oc_in),
      .port_enabled(pen), .dev_connected(dcon));
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : final_report
   // Hang guard, far above the few hundred cycles needed
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         final_report();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wt(input int n);
      repeat (n) @(posedge aclk);
   endtask : wt
   // Each channel released only at its own handshake edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      rsp = bresp;
      bready <= 1'b0;
   endtask : wr
   task automatic rd_reg(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rd = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask : rd_reg
   task automatic t_reset();
      rd_reg(POLS_PORT_OFS);
      chk("port reset", rd, 32'h0000_3001);
      chk("ctl reset", 32'(ctl), 32'h0000_0060);
      $display("done reset");
   endtask : t_reset
   task automatic t_owner();
      wr(POLS_PORT_OFS, 32'hFFF0_C000);
      rd_reg(POLS_PORT_OFS);
      chk("owner held", rd & 32'h0000_E000, 32'h0000_2000);
      wr(POLS_CFG_OFS, 32'h0000_0001);
      wt(2);
      rd_reg(POLS_PORT_OFS);
      chk("owner cleared", rd & 32'h0000_2000, 32'h0000_0000);
      chk("ctl owner", 32'(ctl.owner_companion), 32'h0000_0000);
      $display("done owner");
   endtask : t_owner
   task automatic t_tests();
      logic [4:0] e;
      for (int c = 0; c < 8; c++) begin
         wr(POLS_PORT_OFS, {12'h000, 4'(c), 16'h0000});
         wt(2);
         e = (c == 0 || c > 5) ? 5'h00 : 5'h10 >> (c - 1);
         chk("test ctl", {27'h000_0000, ctl[4:0]}, {27'h000_0000, e});
         rd_reg(POLS_PORT_OFS);
         chk("selector", {28'h000_0000, rd[19:16]}, 32'(c));
      end
      $display("done tests");
   endtask : t_tests
   task automatic t_line();
      for (int v = 0; v < 4; v++) begin
         @(posedge aclk);
         ls_cmd <= 2'(v);
         wt(5);
         rd_reg(POLS_PORT_OFS);
         chk("line state", {30'h0000_0000, rd[11:10]}, 32'(v));
      end
      // Software sees K only on a low-speed device and hands the port away
      @(posedge aclk);
      ls_cmd <= POLS_LS_K;
      wt(5);
      rd_reg(POLS_PORT_OFS);
      if (rd[11:10] === POLS_LS_K) wr(POLS_PORT_OFS, 32'h0000_2000);
      wt(2);
      chk("owner released", 32'(ctl.owner_companion), 32'h0000_0001);
      $display("done line");
   endtask : t_line
   task automatic t_power();
      wr(POLS_CFG_OFS, 32'h0000_0011);
      @(posedge aclk);
      ls_cmd <= 2'h2;
      wr(POLS_PORT_OFS, 32'h0001_0000);
      wt(5);
      rd_reg(POLS_PORT_OFS);
      chk("power off", rd & 32'h0000_3C00, 32'h0000_0000);
      chk("ctl unpowered", {25'h000_0000, ctl}, 32'h0000_0000);
      wr(POLS_PORT_OFS, 32'h0000_1000);
      wt(2);
      rd_reg(POLS_PORT_OFS);
      chk("power on", rd & 32'h0000_1000, 32'h0000_1000);
      chk("ctl power", 32'(ctl.power_on), 32'h0000_0001);
      wr(POLS_MASK_OFS, 32'h0000_0001);
      @(posedge aclk);
      oc_cmd <= 1'b1;
      wt(6);
      oc_cmd <= 1'b0;
      wt(6);
      rd_reg(POLS_PORT_OFS);
      chk("oc power", rd & 32'h0000_1000, 32'h0000_0000);
      chk("ctl oc", 32'(ctl.power_on), 32'h0000_0000);
      chk("irq set", 32'(irq), 32'h0000_0001);
      rd_reg(POLS_STAT_OFS);
      chk("oc status", rd & 32'h0000_0001, 32'h0000_0001);
      wr(POLS_STAT_OFS, 32'h0000_0001);
      wt(3);
      chk("irq clear", 32'(irq), 32'h0000_0000);
      $display("done power");
   endtask : t_power
   task automatic t_unmapped();
      rd_reg(8'h10);
      chk("bad read", {rd[29:0], rsp}, 32'h0000_0002);
      wr(8'h10, 32'hFFFF_FFFF);
      chk("bad write", 32'(rsp), 32'h0000_0002);
      $display("done unmapped");
   endtask : t_unmapped
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_owner();
      t_tests();
      t_line();
      t_power();
      t_unmapped();
      final_report();
   end
endmodule : tb_pols_port
